// ==== include/wdrt_pkg.sv ====
package wdrt_pkg;

    // register bus
    localparam int WDRT_ADDR_W = 12;
    localparam int WDRT_DATA_W = 8;
    localparam logic [11:0] WDRT_OFF_CONTROL = 12'h00c;
    localparam logic [11:0] WDRT_OFF_ID_HIGH = 12'hfeb;
    localparam logic [11:0] WDRT_OFF_ID_LOW = 12'hfec;

    // watchdog_control fields
    localparam int WDRT_FLD_SEL_LSB = 5;
    localparam int WDRT_FLD_SEL_MSB = 7;
    localparam int WDRT_FLD_HW_FLAG = 4;
    localparam int WDRT_FLD_CODE_LSB = 0;
    localparam int WDRT_FLD_CODE_MSB = 3;
    localparam logic [3:0] WDRT_SERVICE_CODE = 4'h5;
    localparam logic [7:0] WDRT_CONTROL_RST_SW = 8'h00;
    localparam logic [7:0] WDRT_CONTROL_RST_HW = 8'h30;
    localparam logic [2:0] WDRT_SEL_RST = 3'h0;
    localparam logic [2:0] WDRT_SEL_HW_FIXED = 3'h1;

    // selection id values
    localparam logic [15:0] WDRT_ID_SOFTWARE = 16'ha596;
    localparam logic [15:0] WDRT_ID_HW_STBY_HALT = 16'ha597;

    // tick sources, index into the raw tick vector
    localparam int WDRT_NUM_SRC = 5;
    localparam logic [2:0] WDRT_SRC_TBT_DIV21 = 3'h0;
    localparam logic [2:0] WDRT_SRC_TBT_DIV20 = 3'h1;
    localparam logic [2:0] WDRT_SRC_WP_DIV14 = 3'h2;
    localparam logic [2:0] WDRT_SRC_WP_DIV13 = 3'h3;
    localparam logic [2:0] WDRT_SRC_LSOSC_DIV16 = 3'h4;

    // upstream timer groups, index into the raw clear vector
    localparam int WDRT_NUM_GRP = 3;
    localparam logic [1:0] WDRT_GRP_TBT = 2'h0;
    localparam logic [1:0] WDRT_GRP_WP = 2'h1;
    localparam logic [1:0] WDRT_GRP_LSOSC = 2'h2;

    // timing
    localparam int WDRT_CLK_PERIOD_NS = 50;
    localparam int WDRT_RESET_PULSE_NS = 200;
    localparam int WDRT_RESET_PULSE_CYCLES =
        (WDRT_RESET_PULSE_NS + WDRT_CLK_PERIOD_NS - 1) / WDRT_CLK_PERIOD_NS;
    localparam int WDRT_STAB_WAIT_CYCLES_DEF = 32768;
    localparam int WDRT_HOLD_CNT_W = 24;

    // decode tick select {hi, lo, lowspeed_osc} into a source index
    function automatic logic [2:0] wdrt_src_of(input logic [2:0] sel);
        logic [2:0] src;
        src = WDRT_SRC_LSOSC_DIV16;
        if (!sel[0]) begin
            case (sel[2:1])
                2'h0: src = WDRT_SRC_TBT_DIV21;
                2'h1: src = WDRT_SRC_TBT_DIV20;
                2'h2: src = WDRT_SRC_WP_DIV14;
                default: src = WDRT_SRC_WP_DIV13;
            endcase
        end
        return src;
    endfunction

    // upstream timer that feeds a source
    function automatic logic [1:0] wdrt_group_of(input logic [2:0] src);
        logic [1:0] grp;
        grp = WDRT_GRP_LSOSC;
        if (src == WDRT_SRC_TBT_DIV21 || src == WDRT_SRC_TBT_DIV20) begin
            grp = WDRT_GRP_TBT;
        end else if (src == WDRT_SRC_WP_DIV14 || src == WDRT_SRC_WP_DIV13) begin
            grp = WDRT_GRP_WP;
        end
        return grp;
    endfunction

endpackage

// ==== include/wdrt_tick_if.sv ====
`timescale 1ns/1ps
interface wdrt_tick_if;
    logic [2:0] sel;
    logic tick;
    logic src_clear;

    modport selector (
        input sel,
        output tick,
        output src_clear
    );

    modport core (
        output sel,
        input tick,
        input src_clear
    );
endinterface

// ==== hdl/wdrt_tick_sel.sv ====
`timescale 1ns/1ps
module wdrt_tick_sel
    import wdrt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // upstream timer outputs and their clear events, asynchronous
    input wire logic [WDRT_NUM_SRC-1:0] src_tick_raw,
    input wire logic [WDRT_NUM_GRP-1:0] src_clear_raw,
    // towards the counter
    wdrt_tick_if.selector tif
);
    logic [WDRT_NUM_SRC-1:0] tick_s1, tick_s2, tick_prev;
    logic [WDRT_NUM_SRC-1:0] next_tick_s1, next_tick_s2, next_tick_prev;
    logic [WDRT_NUM_GRP-1:0] clr_s1, clr_s2, clr_prev;
    logic [WDRT_NUM_GRP-1:0] next_clr_s1, next_clr_s2, next_clr_prev;
    logic tick_q, clr_q, next_tick_q, next_clr_q;
    logic [2:0] src;
    logic [1:0] grp;

    always_comb begin
        next_tick_s1 = src_tick_raw;
        next_tick_s2 = tick_s1;
        next_tick_prev = tick_s2;
        next_clr_s1 = src_clear_raw;
        next_clr_s2 = clr_s1;
        next_clr_prev = clr_s2;
        src = wdrt_src_of(tif.sel);
        grp = wdrt_group_of(src);
        // rising edge of the synchronised level is one tick
        next_tick_q = tick_s2[src] & ~tick_prev[src];
        // only a clear of the timer now feeding us matters
        next_clr_q = clr_s2[grp] & ~clr_prev[grp];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_s1 <= '0;
            tick_s2 <= '0;
            tick_prev <= '0;
            clr_s1 <= '0;
            clr_s2 <= '0;
            clr_prev <= '0;
            tick_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            tick_s1 <= next_tick_s1;
            tick_s2 <= next_tick_s2;
            tick_prev <= next_tick_prev;
            clr_s1 <= next_clr_s1;
            clr_s2 <= next_clr_s2;
            clr_prev <= next_clr_prev;
            tick_q <= next_tick_q;
            clr_q <= next_clr_q;
        end
    end

    assign tif.tick = tick_q;
    assign tif.src_clear = clr_q;
endmodule // wdrt_tick_sel

// ==== hdl/wdrt_reset_gen.sv ====
`timescale 1ns/1ps
module wdrt_reset_gen
    import wdrt_pkg::*;
#(
    parameter int unsigned STAB_WAIT_CYCLES = WDRT_STAB_WAIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request
    input wire logic trigger,
    input wire logic subclock,
    // reset outputs
    output logic wd_reset,
    output logic main_clock_request
);
    typedef enum logic [1:0] {
        RG_IDLE = 2'b01,
        RG_HOLD = 2'b10
    } wdrt_rg_state_t;

    localparam logic [WDRT_HOLD_CNT_W-1:0] PULSE_LEN =
        WDRT_HOLD_CNT_W'(WDRT_RESET_PULSE_CYCLES);
    localparam logic [WDRT_HOLD_CNT_W-1:0] STAB_LEN =
        WDRT_HOLD_CNT_W'(STAB_WAIT_CYCLES + WDRT_RESET_PULSE_CYCLES);

    wdrt_rg_state_t state, next_state;
    logic [WDRT_HOLD_CNT_W-1:0] remain, next_remain;
    logic next_wd_reset, next_main_clock_request;

    always_comb begin
        next_state = state;
        next_remain = remain;
        next_wd_reset = wd_reset;
        next_main_clock_request = main_clock_request;
        case (state)
            RG_IDLE: begin
                if (trigger) begin
                    next_state = RG_HOLD;
                    next_wd_reset = 1'b1;
                    // held through the main oscillator wait when on subclock
                    next_remain = subclock ? STAB_LEN : PULSE_LEN;
                    next_main_clock_request = subclock;
                end
            end
            RG_HOLD: begin
                if (remain <= WDRT_HOLD_CNT_W'(1)) begin
                    next_state = RG_IDLE;
                    next_wd_reset = 1'b0;
                    next_main_clock_request = 1'b0;
                    next_remain = '0;
                end else begin
                    next_remain = remain - WDRT_HOLD_CNT_W'(1);
                end
            end
            default: begin
                next_state = RG_IDLE;
                next_wd_reset = 1'b0;
                next_main_clock_request = 1'b0;
                next_remain = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= RG_IDLE;
            remain <= '0;
            wd_reset <= 1'b0;
            main_clock_request <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            wd_reset <= next_wd_reset;
            main_clock_request <= next_main_clock_request;
        end
    end
endmodule // wdrt_reset_gen

// ==== hdl/wdrt_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module wdrt_top
    import wdrt_pkg::*;
#(
    parameter int unsigned STAB_WAIT_CYCLES = WDRT_STAB_WAIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [WDRT_ADDR_W-1:0] reg_addr,
    input wire logic [WDRT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WDRT_DATA_W-1:0] reg_rdata,
    // upstream timer outputs, asynchronous levels
    input wire logic tbt_div21_out,
    input wire logic tbt_div20_out,
    input wire logic wp_div14_out,
    input wire logic wp_div13_out,
    input wire logic lsosc_div16_out,
    // upstream timer clear events, asynchronous
    input wire logic tbt_cleared,
    input wire logic wp_cleared,
    input wire logic lsosc_cleared,
    // selection id as loaded from non-volatile storage, stable at reset
    input wire logic [WDRT_DATA_W-1:0] select_id_high_in,
    input wire logic [WDRT_DATA_W-1:0] select_id_low_in,
    // power state from the clock controller, asynchronous
    input wire logic standby_active,
    input wire logic subclock_mode,
    // results
    output logic wd_reset,
    output logic main_clock_request,
    output logic watchdog_running
);
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b010,
        ST_RUN = 3'b100
    } wdrt_state_t;

    wdrt_tick_if tif ();

    // mode and configuration state
    wdrt_state_t state, next_state;
    logic hw_mode, next_hw_mode;
    logic run_in_standby, next_run_in_standby;
    logic [WDRT_DATA_W-1:0] id_high, next_id_high;
    logic [WDRT_DATA_W-1:0] id_low, next_id_low;
    logic [2:0] tick_sel, next_tick_sel;
    logic next_watchdog_running;

    // counter state
    logic count, next_count;
    logic overflow, next_overflow;

    // power state synchronisers
    logic stby_s1, stby_s2, stby_prev;
    logic next_stby_s1, next_stby_s2, next_stby_prev;
    logic sub_s1, sub_s2;
    logic next_sub_s1, next_sub_s2;

    // register read
    logic [WDRT_DATA_W-1:0] next_reg_rdata;

    // decoded strobes
    logic ctrl_wr;
    logic service;
    logic stby_entry;
    logic halted;
    logic [15:0] id_value;

    // counter clear causes
    logic clear_service;
    logic clear_source;
    logic clear_standby;
    logic counter_clear;
    logic tick_taken;

    always_comb begin
        ctrl_wr = reg_wr && (reg_addr == WDRT_OFF_CONTROL);
        // any other code is ignored
        service = ctrl_wr &&
            (reg_wdata[WDRT_FLD_CODE_MSB:WDRT_FLD_CODE_LSB] == WDRT_SERVICE_CODE);
        stby_entry = stby_s2 && !stby_prev;
        halted = stby_s2 && !run_in_standby;
        id_value = {select_id_high_in, select_id_low_in};
        // a service write only clears once the watchdog runs
        clear_service = service && (state == ST_RUN);
        clear_source = tif.src_clear;
        // a run-in-standby watchdog ignores standby altogether
        clear_standby = (stby_entry && !run_in_standby) || halted;
        counter_clear = clear_service || clear_source || clear_standby;
        // a tick in the same cycle as a clear is dropped
        tick_taken = tif.tick && !counter_clear;
    end

    // power state synchronisers
    always_comb begin
        // two flops before use; prev only marks the entry edge
        next_stby_s1 = standby_active;
        next_stby_s2 = stby_s1;
        next_stby_prev = stby_s2;
        next_sub_s1 = subclock_mode;
        next_sub_s2 = sub_s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stby_s1 <= 1'b0;
            stby_s2 <= 1'b0;
            stby_prev <= 1'b0;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
        end else begin
            stby_s1 <= next_stby_s1;
            stby_s2 <= next_stby_s2;
            stby_prev <= next_stby_prev;
            sub_s1 <= next_sub_s1;
            sub_s2 <= next_sub_s2;
        end
    end

    // mode control
    always_comb begin
        next_state = state;
        next_hw_mode = hw_mode;
        next_run_in_standby = run_in_standby;
        next_id_high = id_high;
        next_id_low = id_low;
        next_tick_sel = tick_sel;
        next_watchdog_running = watchdog_running;
        case (state)
            ST_LOAD: begin
                // id caught in the first clocked cycle after reset release
                next_id_high = select_id_high_in;
                next_id_low = select_id_low_in;
                if (id_value == WDRT_ID_SOFTWARE) begin
                    next_hw_mode = 1'b0;
                    next_run_in_standby = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    next_hw_mode = 1'b1;
                    next_run_in_standby = (id_value != WDRT_ID_HW_STBY_HALT);
                    next_tick_sel = WDRT_SEL_HW_FIXED;
                    next_watchdog_running = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_IDLE: begin
                if (ctrl_wr) begin
                    // select is taken with every control write while idle
                    next_tick_sel = reg_wdata[WDRT_FLD_SEL_MSB:WDRT_FLD_SEL_LSB];
                end
                if (service) begin
                    next_watchdog_running = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // no write leaves this state, select stays frozen
                next_state = ST_RUN;
                next_watchdog_running = 1'b1;
            end
            default: begin
                next_state = ST_LOAD;
                next_watchdog_running = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_LOAD;
            hw_mode <= 1'b0;
            run_in_standby <= 1'b0;
            id_high <= '0;
            id_low <= '0;
            tick_sel <= WDRT_SEL_RST;
            watchdog_running <= 1'b0;
        end else begin
            state <= next_state;
            hw_mode <= next_hw_mode;
            run_in_standby <= next_run_in_standby;
            id_high <= next_id_high;
            id_low <= next_id_low;
            tick_sel <= next_tick_sel;
            watchdog_running <= next_watchdog_running;
        end
    end

    // counter; a clear in the same cycle as a tick wins, which only
    // lengthens the interval and never fires early
    always_comb begin
        next_count = count;
        next_overflow = 1'b0;
        if (state != ST_RUN) begin
            next_count = 1'b0;
        end else if (counter_clear) begin
            next_count = 1'b0;
        end else if (tick_taken) begin
            if (count) begin
                next_overflow = 1'b1;
                next_count = 1'b0;
            end else begin
                next_count = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 1'b0;
            overflow <= 1'b0;
        end else begin
            count <= next_count;
            overflow <= next_overflow;
        end
    end

    // register read, data valid only in the cycle after the strobe
    always_comb begin
        next_reg_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                WDRT_OFF_CONTROL: begin
                    if (hw_mode) begin
                        // select and status bits locked to their fixed image
                        next_reg_rdata = WDRT_CONTROL_RST_HW;
                        next_reg_rdata[WDRT_FLD_SEL_MSB:WDRT_FLD_SEL_LSB] = WDRT_SEL_HW_FIXED;
                        next_reg_rdata[WDRT_FLD_HW_FLAG] = 1'b1;
                    end else begin
                        // software image shows the select it was given
                        next_reg_rdata = WDRT_CONTROL_RST_SW;
                        next_reg_rdata[WDRT_FLD_SEL_MSB:WDRT_FLD_SEL_LSB] = tick_sel;
                        next_reg_rdata[WDRT_FLD_HW_FLAG] = 1'b0;
                    end
                    next_reg_rdata[WDRT_FLD_CODE_MSB:WDRT_FLD_CODE_LSB] = 4'h0;
                end
                WDRT_OFF_ID_HIGH: next_reg_rdata = id_high;
                WDRT_OFF_ID_LOW: next_reg_rdata = id_low;
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    assign tif.sel = tick_sel;

    // raw vectors follow the package source and group indices
    wdrt_tick_sel u_tick_sel (
        .clk(clk),
        .arst_n(arst_n),
        .src_tick_raw({lsosc_div16_out, wp_div13_out, wp_div14_out,
                       tbt_div20_out, tbt_div21_out}),
        .src_clear_raw({lsosc_cleared, wp_cleared, tbt_cleared}),
        .tif(tif.selector)
    );

    // the generator alone decides how long reset stands
    wdrt_reset_gen #(
        .STAB_WAIT_CYCLES(STAB_WAIT_CYCLES)
    ) u_reset_gen (
        .clk(clk),
        .arst_n(arst_n),
        .trigger(overflow),
        .subclock(sub_s2),
        .wd_reset(wd_reset),
        .main_clock_request(main_clock_request)
    );
endmodule // wdrt_top

// ==== verification/wdrt_top_asserts.sv ====
`timescale 1ns/1ps
module wdrt_top_asserts
    import wdrt_pkg::*;
#(
    parameter int unsigned STAB_WAIT_CYCLES = WDRT_STAB_WAIT_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [WDRT_ADDR_W-1:0] reg_addr,
    input wire logic [WDRT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [WDRT_DATA_W-1:0] reg_rdata,
    // selection id
    input wire logic [WDRT_DATA_W-1:0] select_id_high_in,
    input wire logic [WDRT_DATA_W-1:0] select_id_low_in,
    // results
    input wire logic wd_reset,
    input wire logic main_clock_request,
    input wire logic watchdog_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [31:0] hi_cnt;
    logic [31:0] next_hi_cnt;
    logic settled;
    logic next_settled;
    logic ctl_rd;
    logic start_wr;
    logic id_rd;

    assign ctl_rd = reg_rd && reg_addr == WDRT_OFF_CONTROL;
    assign start_wr = reg_wr && reg_addr == WDRT_OFF_CONTROL && reg_wdata[3:0] == 4'h5;
    assign id_rd = reg_rd && (reg_addr == WDRT_OFF_ID_HIGH || reg_addr == WDRT_OFF_ID_LOW);

    // settled masks the edge where hardware mode switches itself on
    always_comb begin
        next_hi_cnt = wd_reset ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
        next_settled = 1'b1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 32'h0000_0000;
            settled <= 1'b0;
        end else begin
            hi_cnt <= next_hi_cnt;
            settled <= next_settled;
        end
    end

    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read slot");

    property p_code_zero;
        ctl_rd |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_code_zero: assert property (p_code_zero)
        else $error("service field read back not zero");

    property p_hw_image;
        ctl_rd |=> !reg_rdata[4] || reg_rdata == 8'h30;
    endproperty
    a_hw_image: assert property (p_hw_image)
        else $error("hardware mode control image wrong");

    property p_id_read;
        id_rd |=> reg_rdata == ($past(reg_addr) == WDRT_OFF_ID_HIGH ?
            select_id_high_in : select_id_low_in);
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("selection id read wrong");

    property p_start;
        start_wr |=> watchdog_running;
    endproperty
    a_start: assert property (p_start)
        else $error("service code did not start watchdog");

    property p_no_start;
        settled && !watchdog_running && !start_wr |=> !watchdog_running;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("watchdog started without service code");

    property p_sticky;
        watchdog_running |=> watchdog_running;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("running watchdog stopped");

    property p_rst_cause;
        $rose(wd_reset) |-> $past(watchdog_running, 2);
    endproperty
    a_rst_cause: assert property (p_rst_cause)
        else $error("watchdog reset while not running");

    property p_rst_len;
        $fell(wd_reset) |-> hi_cnt == ($past(main_clock_request) ? 4 + STAB_WAIT_CYCLES : 4);
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("watchdog reset length wrong");

    property p_mcr_span;
        main_clock_request |-> wd_reset;
    endproperty
    a_mcr_span: assert property (p_mcr_span)
        else $error("main clock request outside reset");

    c_reset: cover property ($rose(wd_reset));
    c_subclock: cover property ($rose(main_clock_request));
    c_start: cover property ($rose(watchdog_running));
endmodule // wdrt_top_asserts

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
bind wdrt_top wdrt_top_asserts #(.STAB_WAIT_CYCLES(STAB_WAIT_CYCLES)) u_chk (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .select_id_high_in(select_id_high_in), .select_id_low_in(select_id_low_in),
    .wd_reset(wd_reset), .main_clock_request(main_clock_request),
    .watchdog_running(watchdog_running)
);

module testbench
    import wdrt_pkg::*;
;
    localparam int STAB = 8;
    localparam logic [11:0] CTL = WDRT_OFF_CONTROL;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [4:0] src = 5'h00;
    logic [2:0] clr = 3'h0;
    logic [15:0] id = 16'ha596;
    logic standby = 1'b0;
    logic sub = 1'b0;
    logic wd_reset;
    logic mcr;
    logic running;
    int num_errors = 0;
    int checked = 0;

    always #25 clk = ~clk;

    wdrt_top #(.STAB_WAIT_CYCLES(STAB)) u_dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tbt_div21_out(src[0]), .tbt_div20_out(src[1]), .wp_div14_out(src[2]),
        .wp_div13_out(src[3]), .lsosc_div16_out(src[4]),
        .tbt_cleared(clr[0]), .wp_cleared(clr[1]), .lsosc_cleared(clr[2]),
        .select_id_high_in(id[15:8]), .select_id_low_in(id[7:0]),
        .standby_active(standby), .subclock_mode(sub),
        .wd_reset(wd_reset), .main_clock_request(mcr), .watchdog_running(running)
    );

    // arguments are copied at the call, so callers sample after the edge
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset(input logic [15:0] new_id);
        @(posedge clk);
        arst_n <= 1'b0;
        id <= new_id;
        cyc(20);
        arst_n <= 1'b1;
        cyc(3);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // one raw tick, long enough for a subclock reset to end inside it
    task automatic tick(input int idx, input int exp_rst, input int exp_mcr);
        int nr = 0;
        int nm = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            src[idx] <= (i < 8) ? 1'b1 : 1'b0;
            #1;
            nr += (wd_reset === 1'b1) ? 1 : 0;
            nm += (mcr === 1'b1) ? 1 : 0;
        end
        chk(16'(nr), 16'(exp_rst));
        chk(16'(nm), 16'(exp_mcr));
    endtask

    task automatic clear_src(input int g);
        @(posedge clk);
        clr[g] <= 1'b1;
        cyc(4);
        clr[g] <= 1'b0;
        cyc(4);
    endtask

    task automatic set_standby(input logic v);
        @(posedge clk);
        standby <= v;
        cyc(4);
    endtask

    task automatic t_regs();
        do_reset(16'ha596);
        rd(WDRT_OFF_ID_HIGH, 8'ha5);
        rd(WDRT_OFF_ID_LOW, 8'h96);
        rd(CTL, 8'h00);
        rd(12'h00d, 8'h00);
        tick(4, 0, 0);
        tick(4, 0, 0);
        wr(12'h00d, 8'h25);
        wr(CTL, 8'h2a);
        chk(running, 1'b0);
        rd(CTL, 8'h20);
        $display("t_regs done");
    endtask

    task automatic t_decode();
        int want;
        for (int s = 0; s < 8; s++) begin
            want = (s % 2 == 1) ? 4 : s / 2;
            do_reset(16'ha596);
            wr(CTL, {3'(s), 5'h05});
            chk(running, 1'b1);
            rd(CTL, {3'(s), 5'h00});
            for (int k = 0; k < 5; k++) begin
                if (k != want) begin
                    repeat (2) tick(k, 0, 0);
                end
            end
            tick(want, 0, 0);
            tick(want, 4, 0);
        end
        $display("t_decode done");
    endtask

    task automatic t_service();
        do_reset(16'ha596);
        wr(CTL, 8'h25);
        wr(CTL, 8'h45);
        rd(CTL, 8'h20);
        tick(4, 0, 0);
        wr(CTL, 8'h05);
        tick(4, 0, 0);
        wr(CTL, 8'h0a);
        chk(running, 1'b1);
        tick(4, 4, 0);
        do_reset(16'ha596);
        wr(CTL, 8'h85);
        tick(2, 0, 0);
        clear_src(1);
        tick(2, 0, 0);
        // clear of an unselected timer must not help
        clear_src(0);
        tick(2, 4, 0);
        $display("t_service done");
    endtask

    task automatic t_standby();
        do_reset(16'ha596);
        wr(CTL, 8'h25);
        tick(4, 0, 0);
        set_standby(1'b1);
        tick(4, 0, 0);
        tick(4, 0, 0);
        set_standby(1'b0);
        tick(4, 0, 0);
        tick(4, 4, 0);
        $display("t_standby done");
    endtask

    task automatic t_hw();
        do_reset(16'h1234);
        chk(running, 1'b1);
        rd(CTL, 8'h30);
        tick(4, 0, 0);
        wr(CTL, 8'hc5);
        tick(4, 0, 0);
        rd(CTL, 8'h30);
        tick(4, 4, 0);
        do_reset(16'h1234);
        tick(4, 0, 0);
        do_reset(16'h1234);
        tick(4, 0, 0);
        set_standby(1'b1);
        tick(4, 4, 0);
        set_standby(1'b0);
        $display("t_hw done");
    endtask

    task automatic t_halt();
        do_reset(16'ha597);
        chk(running, 1'b1);
        rd(CTL, 8'h30);
        tick(4, 0, 0);
        set_standby(1'b1);
        tick(4, 0, 0);
        tick(4, 0, 0);
        set_standby(1'b0);
        tick(4, 0, 0);
        @(posedge clk);
        sub <= 1'b1;
        tick(4, 4 + STAB, 4 + STAB);
        @(posedge clk);
        sub <= 1'b0;
        $display("t_halt done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        t_regs();
        t_decode();
        t_service();
        t_standby();
        t_hw();
        t_halt();
        give_verdict();
    end
endmodule // testbench
